// ---- core/ccrm_pkg.sv ----
package ccrm_pkg;

   localparam int NREG = 20;
   localparam logic [7:0] ADDR_STEP = 8'h01;

   // Register offsets
   localparam logic [7:0] OFS_AUDIO_CONVERTER_SUBSYSTEM = 8'h01;
   localparam logic [7:0] OFS_VOICE_CONVERTER_SYSTEM = 8'h02;
   localparam logic [7:0] OFS_STATUS_OUTPUT = 8'h0f;
   localparam logic [7:0] OFS_DAC_CHANNEL_SELECT = 8'h10;
   localparam logic [7:0] OFS_DAC_SHARED_FEATURES = 8'h11;
   localparam logic [7:0] OFS_DAC_CHANNEL_ONE = 8'h12;
   localparam logic [7:0] OFS_DAC_CHANNEL_TWO = 8'h13;
   localparam logic [7:0] OFS_DAC_CHANNEL_THREE = 8'h14;
   localparam logic [7:0] OFS_DAC_CHANNEL_FOUR = 8'h15;
   localparam logic [7:0] OFS_DAC_CHANNEL_FIVE = 8'h16;
   localparam logic [7:0] OFS_DAC_CHANNEL_SIX = 8'h17;
   localparam logic [7:0] OFS_MIX_CHANNEL_ONE = 8'h18;
   localparam logic [7:0] OFS_MIX_CHANNEL_TWO = 8'h19;
   localparam logic [7:0] OFS_MIX_CHANNEL_THREE = 8'h1a;
   localparam logic [7:0] OFS_MIX_CHANNEL_FOUR = 8'h1b;
   localparam logic [7:0] OFS_MIX_CHANNEL_FIVE = 8'h1c;
   localparam logic [7:0] OFS_MIX_CHANNEL_SIX = 8'h1d;
   localparam logic [7:0] OFS_VOICE_INPUT_GAIN = 8'h21;
   localparam logic [7:0] OFS_SUPPLEMENTAL_SETTINGS_A = 8'h30;
   localparam logic [7:0] OFS_SUPPLEMENTAL_SETTINGS_B = 8'h31;

   localparam logic [7:0] REG_OFS [0:NREG-1] = '{
      OFS_AUDIO_CONVERTER_SUBSYSTEM, OFS_VOICE_CONVERTER_SYSTEM, OFS_STATUS_OUTPUT,
      OFS_DAC_CHANNEL_SELECT, OFS_DAC_SHARED_FEATURES,
      OFS_DAC_CHANNEL_ONE, OFS_DAC_CHANNEL_TWO, OFS_DAC_CHANNEL_THREE,
      OFS_DAC_CHANNEL_FOUR, OFS_DAC_CHANNEL_FIVE, OFS_DAC_CHANNEL_SIX,
      OFS_MIX_CHANNEL_ONE, OFS_MIX_CHANNEL_TWO, OFS_MIX_CHANNEL_THREE,
      OFS_MIX_CHANNEL_FOUR, OFS_MIX_CHANNEL_FIVE, OFS_MIX_CHANNEL_SIX,
      OFS_VOICE_INPUT_GAIN, OFS_SUPPLEMENTAL_SETTINGS_A, OFS_SUPPLEMENTAL_SETTINGS_B};

   localparam int IDX_STATUS = 2;
   localparam int IDX_SHARED = 4;
   localparam int IDX_DAC_FIRST = 5;
   localparam int IDX_MIX_FIRST = 11;
   localparam int IDX_SUPP_B = 19;

   // Field layout of feature words
   localparam int POS_ICS = 14;
   localparam int POS_DE = 11;
   localparam int POS_PD = 10;
   localparam int POS_MT = 9;
   localparam int POS_QM = 8;
   localparam int POS_VC = 0;
   localparam int POS_SOFT_MUTE = 0;

   localparam logic [15:0] MASK_ALL = 16'hffff;
   localparam logic [15:0] MASK_NO_ICS = 16'h3fff;
   localparam logic [15:0] MASK_NO_DE = 16'hc7ff;
   localparam logic [15:0] MASK_NO_ICS_DE = 16'h07ff;
   localparam logic [15:0] MASK_NONE = 16'h0000;

   // Bits that hold state on a direct write
   localparam logic [15:0] WR_MASK [0:NREG-1] = '{
      MASK_ALL, MASK_ALL, MASK_NONE, MASK_ALL, MASK_ALL,
      MASK_ALL, MASK_ALL, MASK_ALL, MASK_ALL, MASK_ALL, MASK_ALL,
      MASK_NO_DE, MASK_NO_ICS_DE, MASK_NO_DE, MASK_NO_ICS_DE, MASK_NO_DE, MASK_NO_ICS_DE,
      MASK_ALL, MASK_ALL, MASK_ALL};

   // Fields taken over from a shared feature write
   localparam logic [15:0] BC_MASK [0:NREG-1] = '{
      MASK_NONE, MASK_NONE, MASK_NONE, MASK_NONE, MASK_NONE,
      MASK_ALL, MASK_NO_ICS, MASK_ALL, MASK_NO_ICS, MASK_ALL, MASK_NO_ICS,
      MASK_NO_DE, MASK_NO_ICS_DE, MASK_NO_DE, MASK_NO_ICS_DE, MASK_NO_DE, MASK_NO_ICS_DE,
      MASK_NONE, MASK_NONE, MASK_NONE};

   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic SOFT_MUTE_DEFAULT = 1'b0;
   localparam int SOFT_MUTE_LONG_SAMPLES = 2048;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } ccrm_byte_type;

   typedef struct packed {
      logic [1:0] input_channel_selection;
      logic [2:0] deemphasis_setting;
      logic channel_power_down;
      logic channel_mute;
      logic quick_mute_select;
      logic [7:0] volume_code;
   } ccrm_chan_type;

endpackage

// ---- core/ccrm_register_map.sv ----
`timescale 1ns/1ns
module ccrm_register_map
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Transfer control from the serial port
   input wire logic xfer_start_in,
   input wire logic [7:0] xfer_addr_in,
   input ccrm_pkg::ccrm_byte_type wr_byte_in,
   input wire logic rd_byte_req_in,
   // Device state shown in the status register
   input wire logic [15:0] status_in,
   // Read answer
   output logic [7:0] rd_byte_out,
   output logic rd_byte_valid_out,
   output logic addr_valid_out,
   // Settings to the converters
   output logic [ccrm_pkg::NREG-1:0][15:0] settings_out,
   output ccrm_pkg::ccrm_chan_type [5:0] dac_chan_out,
   output ccrm_pkg::ccrm_chan_type [5:0] mix_chan_out,
   output logic soft_mute_long_out
);
   import ccrm_pkg::*;

   logic [15:0] regs [0:NREG-1];
   logic [7:0] addr_ptr;
   logic second_byte;
   logic [7:0] held_msb;
   logic wr_commit;
   logic [15:0] wr_word;
   logic [15:0] rd_word;
   logic [4:0] ptr_idx;
   logic ptr_hit;

   // Address decode, shared by write and read
   function automatic logic [5:0] decode(input logic [7:0] addr);
      logic [5:0] res;
      res = 6'h00;
      for (int i = 0; i < NREG; i++)
      begin
         if (REG_OFS[i] == addr)
         begin
            res = {1'b1, 5'(i)};
         end
      end
      return res;
   endfunction

   assign {ptr_hit, ptr_idx} = decode(addr_ptr);
   assign addr_valid_out = ptr_hit;

   assign wr_commit = wr_byte_in.valid && second_byte && !xfer_start_in;
   assign wr_word = {held_msb, wr_byte_in.data};

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         addr_ptr <= 8'h00;
         second_byte <= 1'b0;
         held_msb <= 8'h00;
      end
      else if (xfer_start_in)
      begin
         addr_ptr <= xfer_addr_in;
         second_byte <= 1'b0;
      end
      else if (wr_byte_in.valid || rd_byte_req_in)
      begin
         second_byte <= !second_byte;
         if (!second_byte)
         begin
            held_msb <= wr_byte_in.data;
         end
         else
         begin
            addr_ptr <= addr_ptr + ADDR_STEP;
         end
      end
   end

   // Storage with direct and broadcast writes
   for (genvar g = 0; g < NREG; g++)
   begin : g_reg
      if (g == IDX_STATUS)
      begin : g_ro
         assign regs[g] = status_in;
      end
      else
      begin : g_rw
         always_ff @(posedge clk_in or posedge rst_in)
         begin
            if (rst_in)
            begin
               regs[g] <= RESET_WORD;
            end
            else if (wr_commit && ptr_hit && ptr_idx == 5'(g))
            begin
               regs[g] <= wr_word & WR_MASK[g];
            end
            else if (wr_commit && ptr_hit && ptr_idx == 5'(IDX_SHARED))
            begin
               regs[g] <= (regs[g] & ~BC_MASK[g]) | (wr_word & BC_MASK[g]);
            end
         end
      end
      assign settings_out[g] = regs[g];
   end

   // status read comes straight from the device
   assign rd_word = ptr_hit ? regs[ptr_idx] : 16'h0000;

   // most significant byte goes out first
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rd_byte_out <= 8'h00;
         rd_byte_valid_out <= 1'b0;
      end
      else
      begin
         rd_byte_valid_out <= rd_byte_req_in && !xfer_start_in;
         if (rd_byte_req_in && !xfer_start_in)
         begin
            rd_byte_out <= second_byte ? rd_word[7:0] : rd_word[15:8];
         end
      end
   end

   for (genvar c = 0; c < 6; c++)
   begin : g_chan
      assign dac_chan_out[c] = ccrm_chan_type'(regs[IDX_DAC_FIRST + c]);
      assign mix_chan_out[c] = ccrm_chan_type'(regs[IDX_MIX_FIRST + c]);
   end

   assign soft_mute_long_out = regs[IDX_SUPP_B][POS_SOFT_MUTE] == SOFT_MUTE_DEFAULT;

endmodule // ccrm_register_map

// ---- test/ccrm_register_map_asserts.sv ----
`timescale 1ns/1ns
module ccrm_register_map_asserts
(
   // Clock
   input wire logic clk_in,
   input wire logic rst_in,
   // Requests
   input wire logic xfer_start_in,
   input ccrm_pkg::ccrm_byte_type wr_byte_in,
   input wire logic rd_byte_req_in,
   input wire logic [15:0] status_in,
   // Answers
   input wire logic [7:0] rd_byte_out,
   input wire logic rd_byte_valid_out,
   input wire logic [ccrm_pkg::NREG-1:0][15:0] settings_out,
   input ccrm_pkg::ccrm_chan_type [5:0] mix_chan_out,
   input wire logic soft_mute_long_out
);
   import ccrm_pkg::*;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   logic rq;
   logic [15:0] odd_or;
   logic [15:0] even_or;
   assign rq = rd_byte_req_in && !xfer_start_in;
   assign odd_or = settings_out[11] | settings_out[13] | settings_out[15];
   assign even_or = settings_out[12] | settings_out[14] | settings_out[16];
   a_read_answer: assert property (rq |=> rd_byte_valid_out)
      else $error("no read byte");
   a_read_quiet: assert property (!rq |=> !rd_byte_valid_out)
      else $error("stray read byte");
   a_read_hold: assert property (!rd_byte_valid_out |-> $stable(rd_byte_out))
      else $error("read byte moved");
   a_mix_unused: assert property ((odd_or & 16'h3800) == 0 && (even_or & 16'hf800) == 0)
      else $error("unused mix bit set");
   a_soft_mute: assert property (soft_mute_long_out == !settings_out[19][0])
      else $error("mute length wrong");
   a_status_live: assert property (settings_out[2] == status_in)
      else $error("status not live");
   a_quiet_hold: assert property (!wr_byte_in.valid |=> $stable(settings_out[19:3]))
      else $error("register moved");
   a_mix_view: assert property (16'(mix_chan_out[0]) == settings_out[11])
      else $error("mix view wrong");
endmodule // ccrm_register_map_asserts
bind ccrm_register_map ccrm_register_map_asserts u_chk (.clk_in, .rst_in, .xfer_start_in,
   .wr_byte_in, .rd_byte_req_in, .status_in, .rd_byte_out, .rd_byte_valid_out,
   .settings_out, .mix_chan_out, .soft_mute_long_out);

// ---- test/ccrm_host.sv ----
`timescale 1ns/1ns
module ccrm_host
(
   // Clock and answer
   input wire logic clk_in,
   input wire logic [7:0] rd_byte_in,
   // Requests
   output logic start_out,
   output logic [7:0] addr_out,
   output ccrm_pkg::ccrm_byte_type wb_out,
   output logic req_out
);
   import ccrm_pkg::*;
   // host drives whole bytes, no bit clock to pace
   initial {start_out, addr_out, wb_out, req_out} = '0;
   task automatic xfer(input logic [7:0] a, input bit w, input logic [31:0] d,
      input int n, input int g, output logic [31:0] q);
      @(negedge clk_in) {start_out, addr_out} = {1'b1, a};
      @(negedge clk_in) {start_out, addr_out} = {1'b0, ~a};
      for (int i = 2 * n - 1; i >= 0; i--)
      begin
         {wb_out, req_out} = {w, d[8 * i +: 8], !w};
         @(negedge clk_in) q[8 * i +: 8] = rd_byte_in;
         if (g > 0) {wb_out, req_out} = {1'b0, ~d[8 * i +: 8], 1'b0};
         repeat (g) @(negedge clk_in);
      end
      {wb_out, req_out} = {1'b0, ~wb_out.data, 1'b0};
   endtask
endmodule // ccrm_host

// ---- test/test_codec_control_register_map.sv ----
`timescale 1ns/1ns
module test_codec_control_register_map;
   import ccrm_pkg::*;
   logic clk_in = 0;
   logic rst_in = 1;
   logic start, req, valid, smute;
   logic [7:0] addr, rbyte;
   ccrm_byte_type wb;
   logic avalid;
   ccrm_chan_type [5:0] dac;
   logic [15:0] status_in = 16'ha55a;
   logic [NREG-1:0][15:0] st;
   logic [31:0] q;
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;
   initial forever #2 clk_in = ~clk_in;
   ccrm_register_map dut (.clk_in, .rst_in, .xfer_start_in(start), .xfer_addr_in(addr),
      .wr_byte_in(wb), .rd_byte_req_in(req), .status_in, .rd_byte_out(rbyte),
      .rd_byte_valid_out(valid), .addr_valid_out(avalid), .settings_out(st), .dac_chan_out(dac),
      .mix_chan_out(), .soft_mute_long_out(smute));
   ccrm_host host (.clk_in, .rd_byte_in(rbyte), .start_out(start), .addr_out(addr),
      .wb_out(wb), .req_out(req));
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e)
      begin
         fails++;
         $display("mismatch %0t seen %h want %h", $time, s, e);
      end
   endtask
   task automatic wrap_up;
      $display("fails %0d compares %0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic t_reset;
      chk(smute, 1);
      for (int i = 11; i < 17; i++)
         chk(st[i], 0);
   endtask
   task automatic t_bcast;
      host.xfer(8'h11, 1, 32'hffff, 1, 0, q);
      chk(st[5], 16'hffff);
      chk(st[6], 16'h3fff);
      chk(st[11], 16'hc7ff);
      chk(st[12], 16'h07ff);
      host.xfer(8'h19, 0, 0, 1, 1, q);
      chk(q[15:0], 16'h07ff);
      chk(avalid, 1);
      chk(dac[0].input_channel_selection, 3);
      chk(dac[1].input_channel_selection, 0);
      chk(dac[1].deemphasis_setting, 7);
   endtask
   task automatic t_direct;
      host.xfer(8'h19, 1, 32'hf8a5_1234, 2, 0, q);
      chk(st[12], 16'h00a5);
      chk(st[13], 16'h0234);
      chk(st[11], 16'hc7ff);
      chk(st[4], 16'hffff);
   endtask
   task automatic t_read;
      // Status word refuses the write, pointer still steps
      host.xfer(8'h0f, 1, 32'h1111_2222, 2, 1, q);
      chk(st[3], 16'h2222);
      host.xfer(8'h0f, 0, 0, 2, 0, q);
      chk(q[31:16], 16'ha55a);
      chk(q[15:0], 16'h2222);
      host.xfer(8'h03, 0, 0, 1, 2, q);
      chk(q[15:0], 0);
      chk(avalid, 0);
   endtask
   task automatic t_map;
      for (int i = 0; i < NREG; i++)
         if (i != 2) host.xfer(REG_OFS[i], 1, 32'h0700 + i, 1, 0, q);
      for (int i = 0; i < NREG; i++)
         chk(st[i], i == 2 ? status_in : 16'h0700 + i);
      chk(smute, 0);
   endtask
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         fails++;
         wrap_up;
      end
   end
   initial
   begin
      repeat (12) @(posedge clk_in);
      @(negedge clk_in) rst_in = 0;
      t_reset;
      t_bcast;
      t_direct;
      t_read;
      t_map;
      wrap_up;
   end
endmodule // test_codec_control_register_map
